// ===== cfo_console.sv
`timescale 1ns/1ps
module cfo_console
    import cfo_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // panel pins, asynchronous
    input wire logic power_ok,
    input wire logic autorestart,
    input wire logic lockout,
    input wire logic transmit_key,
    input wire logic display_key,
    input wire logic stop_key,
    input wire logic cont_key,
    input wire logic [WORD_W-1:0] switches,
    input wire logic [ADDR_W-1:0] device_select,
    // memory port
    output logic mem_rd_q,
    output logic [WORD_W-1:0] mem_addr_q,
    input wire logic [WORD_W-1:0] mem_rdata,
    input wire logic mem_ack,
    // device bus
    output logic [ADDR_W-1:0] bus_src_q,
    output logic [ADDR_W-1:0] bus_dst_q,
    input wire logic [WORD_W-1:0] bus_rdata,
    input wire logic [IND_W-1:0] bus_status,
    output logic [WORD_W-1:0] bus_wdata_q,
    output logic bus_wr_q,
    output logic [MOD_W-1:0] func_pulse_q,
    // teleprinter
    input wire logic [TTY_W-1:0] tti_data,
    input wire logic tto_done,
    output logic [TTY_W-1:0] tto_char_q,
    output logic tto_strobe_q,
    output logic tto_ready_q,
    // lamps
    output logic [WORD_W-1:0] ir_q,
    output logic [WORD_W-1:0] sc_q,
    output logic [WORD_W-1:0] ma_q,
    output logic [WORD_W-1:0] mb_q,
    output logic [WORD_W-1:0] dd_q,
    output logic run_q,
    output logic halt_q
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 7 + WORD_W + ADDR_W;
    logic [NSYNC-1:0] s1_q;
    logic [NSYNC-1:0] s2_q;
    logic [3:0] key_prev_q;
    wire [NSYNC-1:0] pins = {power_ok, autorestart, lockout, transmit_key, display_key,
                             stop_key, cont_key, switches, device_select};

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            s1_q <= '0;
            s2_q <= '0;
        end
        else
        begin
            s1_q <= pins;
            s2_q <= s1_q;
        end
    end

    wire pwr_s = s2_q[NSYNC-1];
    wire auto_s = s2_q[NSYNC-2];
    wire lock_s = s2_q[NSYNC-3];
    wire [3:0] keys_s = s2_q[NSYNC-4 -: 4];
    // switch pressed drives one straight through
    wire [WORD_W-1:0] sw_s = s2_q[ADDR_W +: WORD_W];
    wire [ADDR_W-1:0] sel_s = s2_q[ADDR_W-1:0];

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            key_prev_q <= '0;
        else
            key_prev_q <= keys_s;
    end

    // lockout masks operating keys only; sw_s is not gated
    wire [3:0] key_edge = keys_s & ~key_prev_q & {4{~lock_s}};
    wire trm_k = key_edge[3];
    wire display_key_k = key_edge[2];
    wire stop_k = key_edge[1];
    wire cont_k = key_edge[0];

    // ------------------------------------------------------------
    // decode helper
    // ------------------------------------------------------------
    cfo_dec_if dif ();
    cfo_decode u_dec (
        .d(dif.dec)
    );
    assign dif.instr = ir_q;
    assign dif.status = bus_status;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    cfo_state_e st_q;
    cfo_state_e st_d;
    logic pwr_prev_q;
    logic [PDOWN_W-1:0] pd_cnt_q;
    localparam logic [PDOWN_W-1:0] PD_LAST = PDOWN_W'(PDOWN_CYC - 1);

    wire pwr_rise = pwr_s & ~pwr_prev_q;
    wire pwr_fall = ~pwr_s & pwr_prev_q;
    wire pd_done = (st_q == ST_PDOWN) && (pd_cnt_q == PD_LAST);
    wire halted = (st_q == ST_HALT);
    wire [ADDR_W-1:0] ir_src = ir_q[SRC_LSB +: ADDR_W];
    wire [ADDR_W-1:0] ir_dst = ir_q[DST_LSB +: ADDR_W];
    wire [MOD_W-1:0] ir_mod = ir_q[MOD_LSB +: MOD_W];
    wire exec_go = (st_q == ST_EXEC);
    wire xfer_go = exec_go && !dif.is_fgen && !dif.is_ftest && !dif.two_word;

    // internal sources ahead of the external bus
    function automatic logic [WORD_W-1:0] read_src(input logic [ADDR_W-1:0] a);
        logic [WORD_W-1:0] r;
        r = bus_rdata;
        if (a == DEV_SWITCH)
            r = sw_s;
        else if (a == DEV_SEQ)
            r = sc_q;
        else if (a == DEV_TTY)
            r = {{(WORD_W-TTY_W){1'b0}}, tti_data};
        return r;
    endfunction : read_src

    wire [WORD_W-1:0] xfer_data = read_src(ir_src);
    wire [WORD_W-1:0] display_key_data = read_src(sel_s);
    wire key_trm = halted && trm_k;
    wire key_display_key = halted && display_key_k && !trm_k;

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            ST_OFF:
                if (pwr_rise)
                    st_d = auto_s ? ST_FETCH : ST_HALT;
            ST_HALT:
                if (cont_k)
                    st_d = ST_FETCH;
            ST_FETCH:
                if (mem_rd_q && mem_ack)
                    st_d = ST_DECODE;
            ST_DECODE:
                st_d = dif.two_word ? ST_FETCH2 : ST_EXEC;
            ST_FETCH2:
                if (mem_rd_q && mem_ack)
                    st_d = ST_EXEC;
            ST_EXEC:
                st_d = halt_q ? ST_HALT : ST_FETCH;
            ST_PDOWN:
                if (pd_done)
                    st_d = ST_OFF;
            default:
                st_d = ST_OFF;
        endcase
        if (pwr_fall)
            st_d = ST_PDOWN;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q <= ST_OFF;
            pwr_prev_q <= 1'b0;
            pd_cnt_q <= '0;
        end
        else
        begin
            st_q <= st_d;
            pwr_prev_q <= pwr_s;
            pd_cnt_q <= (st_q == ST_PDOWN) ? pd_cnt_q + 1'b1 : '0;
        end
    end

    // ------------------------------------------------------------
    // halt latch, run lamp
    // ------------------------------------------------------------
    // stop held at power-up is caught at the rise, so one instruction runs
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            halt_q <= 1'b0;
        else if (pd_done)
            halt_q <= 1'b0;
        else if (pwr_rise)
            halt_q <= keys_s[1];
        else if (stop_k)
            halt_q <= 1'b1;
        else if (halted && cont_k)
            halt_q <= 1'b0;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            run_q <= 1'b0;
        else
            run_q <= (st_d != ST_OFF) && (st_d != ST_HALT) && (st_d != ST_PDOWN);
    end

    // ------------------------------------------------------------
    // memory fetch and registers
    // ------------------------------------------------------------
    wire fetch_start = (st_q == ST_FETCH || st_q == ST_FETCH2) && !mem_rd_q;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            mem_rd_q <= 1'b0;
            mem_addr_q <= '0;
            ma_q <= '0;
        end
        else if (mem_rd_q && mem_ack)
            mem_rd_q <= 1'b0;
        else if (fetch_start)
        begin
            mem_rd_q <= 1'b1;
            mem_addr_q <= sc_q;
            ma_q <= sc_q;
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            ir_q <= '0;
            mb_q <= '0;
        end
        else if (pd_done)
        begin
            ir_q <= '0;
            mb_q <= '0;
        end
        else if (mem_rd_q && mem_ack)
        begin
            mb_q <= mem_rdata;
            if (st_q == ST_FETCH)
                ir_q <= mem_rdata;
        end
    end

    // sequence counter
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            sc_q <= START_LOC;
        else if (pwr_rise)
            sc_q <= START_LOC;
        else if (mem_rd_q && mem_ack)
            sc_q <= sc_q + NEXT_STEP;
        else if (exec_go && dif.is_ftest && dif.test_pass)
            sc_q <= sc_q + SKIP_STEP;
        else if (xfer_go && ir_dst == DEV_SEQ)
            sc_q <= xfer_data;
        else if (key_trm && sel_s == DEV_SEQ)
            sc_q <= sw_s;
    end

    // ------------------------------------------------------------
    // device bus, function pulses
    // ------------------------------------------------------------
    wire ext_trm = key_trm && sel_s != DEV_SEQ;
    wire ext_xfer = xfer_go && ir_dst != DEV_SEQ;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            bus_src_q <= '0;
            bus_dst_q <= '0;
            bus_wdata_q <= '0;
            bus_wr_q <= 1'b0;
            func_pulse_q <= '0;
        end
        else
        begin
            bus_wr_q <= ext_trm || ext_xfer;
            func_pulse_q <= (exec_go && dif.is_fgen) ? ir_mod : '0;
            if (st_q == ST_DECODE)
            begin
                bus_src_q <= ir_src;
                bus_dst_q <= ir_dst;
            end
            else if (halted)
            begin
                // panel addresses one device at a time
                bus_src_q <= sel_s;
                bus_dst_q <= sel_s;
            end
            if (ext_trm)
                bus_wdata_q <= sw_s;
            else if (ext_xfer)
                bus_wdata_q <= xfer_data;
        end
    end

    // ------------------------------------------------------------
    // data display and teleprinter output
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            dd_q <= '0;
        else if (key_display_key)
            dd_q <= display_key_data;
    end

    wire tto_trm = key_trm && sel_s == DEV_TTY;
    wire tto_echo = key_display_key && sel_s == DEV_TTY;
    wire tto_prog = xfer_go && ir_dst == DEV_TTY;
    wire tto_send = tto_trm || tto_echo || tto_prog;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            tto_char_q <= '0;
            tto_strobe_q <= 1'b0;
            tto_ready_q <= 1'b0;
        end
        else
        begin
            tto_strobe_q <= tto_send;
            if (tto_trm)
                tto_char_q <= sw_s[TTY_W-1:0];
            else if (tto_echo)
                tto_char_q <= tti_data;
            else if (tto_prog)
                tto_char_q <= xfer_data[TTY_W-1:0];
            // completion beats a same-cycle send so no ready is lost
            if (pd_done)
                tto_ready_q <= 1'b0;
            else if (pwr_rise || tto_done)
                tto_ready_q <= 1'b1;
            else if (tto_send)
                tto_ready_q <= 1'b0;
        end
    end
endmodule : cfo_console

// ===== cfo_console_asserts.sv
`timescale 1ns/1ps
module cfo_console_asserts
    import cfo_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // panel
    input wire logic power_ok,
    input wire logic lockout,
    input wire logic [WORD_W-1:0] switches,
    // memory and device bus
    input wire logic mem_rd_q,
    input wire logic [WORD_W-1:0] mem_addr_q,
    input wire logic mem_ack,
    input wire logic [ADDR_W-1:0] bus_src_q,
    input wire logic [ADDR_W-1:0] bus_dst_q,
    input wire logic [WORD_W-1:0] bus_wdata_q,
    input wire logic bus_wr_q,
    input wire logic [MOD_W-1:0] func_pulse_q,
    // teleprinter and lamps
    input wire logic tto_done,
    input wire logic tto_strobe_q,
    input wire logic tto_ready_q,
    input wire logic [WORD_W-1:0] ir_q,
    input wire logic [WORD_W-1:0] sc_q,
    input wire logic run_q,
    input wire logic halt_q
);
    // ----------
    // power-down timer, counts from the pin so the sync lag is covered
    // ----------
    logic [12:0] pd_cnt_q;
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            pd_cnt_q <= '0;
        else if (power_ok)
            pd_cnt_q <= '0;
        else if (pd_cnt_q != 13'h1fff)
            pd_cnt_q <= pd_cnt_q + 13'h1;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    // ----------
    // properties
    // ----------
    AST_FGEN: assert property (
        func_pulse_q != 4'h0 |-> ir_q[15:10] == DEV_FUNC && func_pulse_q == ir_q[9:6]
        && bus_dst_q == ir_q[5:0]) else $error("function pulse without its instruction");
    AST_FETCH_STEP: assert property (
        power_ok && mem_rd_q && mem_ack |=> sc_q == $past(sc_q) + 16'h1)
        else $error("sequence counter did not step after fetch");
    AST_REQ_HOLD: assert property (
        power_ok && mem_rd_q && !mem_ack |=> mem_rd_q && $stable(mem_addr_q))
        else $error("fetch request dropped before ack");
    AST_LOCKOUT: assert property (
        (lockout && power_ok && !run_q) [*6] |-> $stable(sc_q))
        else $error("locked panel changed the counter");
    AST_HALT_SC: assert property (
        !run_q && !$past(run_q) && !$past(mem_ack) && $past(power_ok, 8) && $changed(sc_q)
        |-> sc_q == switches) else $error("halted counter loaded from elsewhere");
    AST_SWITCH_WR: assert property (
        bus_wr_q && bus_src_q == DEV_SWITCH |-> bus_wdata_q == switches)
        else $error("switch source carried wrong data");
    AST_TTO_READY: assert property (
        tto_strobe_q && !$past(tto_done) |-> !tto_ready_q)
        else $error("output ready kept during send");
    AST_PWRUP: assert property (
        $rose(power_ok) |-> ##[2:8] (tto_ready_q && sc_q == START_LOC))
        else $error("power-up did not preset ready and start location");
    AST_PDOWN: assert property (
        pd_cnt_q == 13'h0dc0 |-> !tto_ready_q && !halt_q && ir_q == 16'h0)
        else $error("power-down left state uncleared");
    cover property (func_pulse_q == 4'ha);
    cover property (mem_rd_q && mem_ack && mem_addr_q == START_LOC);
    cover property (tto_strobe_q && bus_dst_q == DEV_TTY);
endmodule : cfo_console_asserts

bind cfo_console cfo_console_asserts i_chk (.clock, .rstn, .power_ok, .lockout, .switches,
    .mem_rd_q, .mem_addr_q, .mem_ack, .bus_src_q, .bus_dst_q, .bus_wdata_q, .bus_wr_q,
    .func_pulse_q, .tto_done, .tto_strobe_q, .tto_ready_q, .ir_q, .sc_q, .run_q, .halt_q);

// ===== cfo_console_bench.sv
`timescale 1ns/1ps
module cfo_console_bench
    import cfo_pkg::*;
;
    localparam logic [5:0] PA [8] = '{6'h20, 6'h21, 6'h24, 6'h25, 6'h28, 6'h29, 6'h2b, 6'h2c};
    localparam logic [15:0] PW [8] = '{16'h0a91, 16'h3202, 16'h3102, 16'h43c2, 16'h2015,
        16'h1815, 16'h3242, 16'h2007};
    logic clock, rstn, power_ok, autorestart, lockout, mem_rd_q, mem_ack, bus_wr_q;
    logic tto_done, tto_strobe_q, tto_ready_q, run_q, halt_q;
    logic [3:0] keys;
    logic [WORD_W-1:0] switches, mem_addr_q, mem_rdata, bus_rdata, bus_wdata_q, ir_q, sc_q;
    logic [WORD_W-1:0] ma_q, mb_q, dd_q, sw;
    logic [ADDR_W-1:0] device_select, bus_src_q, bus_dst_q;
    logic [MOD_W-1:0] func_pulse_q;
    logic [IND_W-1:0] bus_status;
    logic [TTY_W-1:0] tti_data, tto_char_q, teleprinter_input;
    logic [WORD_W-1:0] got_q[$], exp_q[$], tto_q[$], wr_q[$];
    int n_mismatch, cmp_count, fn_seen, k;
    cfo_console i_dut (.clock, .rstn, .power_ok, .autorestart, .lockout,
        .transmit_key(keys[0]), .display_key(keys[1]), .stop_key(keys[2]),
        .cont_key(keys[3]), .switches, .device_select, .mem_rd_q, .mem_addr_q, .mem_rdata,
        .mem_ack, .bus_src_q, .bus_dst_q, .bus_rdata, .bus_status, .bus_wdata_q, .bus_wr_q,
        .func_pulse_q, .tti_data, .tto_done, .tto_char_q, .tto_strobe_q, .tto_ready_q,
        .ir_q, .sc_q, .ma_q, .mb_q, .dd_q, .run_q, .halt_q);
    cfo_far_end i_far (.clock, .rstn, .mem_rd_q, .mem_addr_q, .mem_rdata, .mem_ack,
        .bus_src_q, .func_pulse_q, .bus_rdata, .bus_status, .tto_strobe_q, .tto_done);
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    always @(posedge clock)
    begin
        if (mem_rd_q && mem_ack)
            got_q.push_back(mem_addr_q);
        if (tto_strobe_q)
            tto_q.push_back({8'h0, tto_char_q});
        if (bus_wr_q)
            wr_q.push_back(bus_wdata_q);
        if (func_pulse_q == 4'ha)
            fn_seen++;
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic press(input int b, input logic [5:0] sel);
        device_select <= sel;
        keys[b] <= 1'b1;
        repeat (4) @(posedge clock);
        keys[b] <= 1'b0;
        repeat (8) @(posedge clock);
    endtask : press
    // expected fetch addresses, worked out from the program words
    task automatic model(input int pc, input int n);
        int w, m, s, d, ok;
        exp_q = {};
        repeat (n)
        begin
            w = i_far.mem[pc % 64];
            s = w >> 10;
            m = (w >> 6) & 15;
            d = w & 63;
            exp_q.push_back(16'(pc));
            if (s == 6 || d == 6 || d == 3)
            begin
                exp_q.push_back(16'(pc + 1));
                pc += 2;
            end
            else if (d == 2 && s != 2)
            begin
                ok = (m & 1) ? ((s & 7 & (m >> 1)) == 0) : ((s & 7 & (m >> 1)) != 0);
                pc += ok ? 3 : 1;
            end
            else if (d == 7 && s != 2)
                pc = int'(switches);
            else
                pc += 1;
        end
    endtask : model
    task automatic close_out;
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out
    initial
    begin
        repeat (12000) @(posedge clock);
        n_mismatch++;
        close_out();
    end
    initial
    begin
        void'($urandom(32'h7e08));
        rstn = 1'b0;
        power_ok = 1'b0;
        autorestart = 1'b0;
        lockout = 1'b0;
        keys = 4'h0;
        switches = 16'h0;
        device_select = 6'h0;
        tti_data = 8'h0;
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        chk("reset sc", sc_q, START_LOC);
        power_ok <= 1'b1;
        repeat (10) @(posedge clock);
        chk("pwrup sc", sc_q, START_LOC);
        chk("pwrup ready", 16'(tto_ready_q), 16'h1);
        chk("pwrup run", 16'(run_q), 16'h0);
        repeat (4)
        begin
            sw = 16'($urandom);
            switches <= sw;
            press(0, DEV_SEQ);
            chk("transmit sc", sc_q, sw);
            press(1, DEV_SWITCH);
            chk("display", dd_q, sw);
            chk("display sc", sc_q, sw);
        end
        wr_q = {};
        press(0, DEV_TTY);
        chk("tto char", tto_q.pop_front(), {8'h0, sw[7:0]});
        chk("writes", 16'(wr_q.size()), 16'h1);
        teleprinter_input = 8'($urandom);
        tti_data <= teleprinter_input;
        press(1, DEV_TTY);
        chk("display tti", dd_q, {8'h0, teleprinter_input});
        chk("echo", tto_q.pop_front(), {8'h0, teleprinter_input});
        lockout <= 1'b1;
        switches <= ~sw;
        press(0, DEV_SEQ);
        press(1, DEV_SWITCH);
        chk("locked sc", sc_q, sw);
        chk("locked dd", dd_q, {8'h0, teleprinter_input});
        lockout <= 1'b0;
        foreach (PA[i])
            i_far.mem[PA[i]] = PW[i];
        switches <= 16'h0020;
        press(0, DEV_SEQ);
        got_q = {};
        wr_q = {};
        press(3, 6'h0);
        repeat (60) @(posedge clock);
        press(2, 6'h0);
        for (k = 0; k < 100 && run_q !== 1'b0; k++)
            @(posedge clock);
        chk("halted", 16'(run_q), 16'h0);
        model(32'h20, got_q.size());
        chk("fetches", 16'(got_q.size() > 8), 16'h1);
        foreach (got_q[i])
            chk("fetch", got_q[i], exp_q[i]);
        chk("fgen", 16'(fn_seen > 0), 16'h1);
        chk("src switches", wr_q[0], 16'h0020);
        chk("ma lamp", ma_q, exp_q[got_q.size()-1]);
        chk("mb lamp", mb_q, i_far.mem[exp_q[got_q.size()-1][5:0]]);
        power_ok <= 1'b0;
        repeat (3400) @(posedge clock);
        chk("pdown early", 16'(tto_ready_q && halt_q), 16'h1);
        repeat (150) @(posedge clock);
        chk("pdown ready", 16'(tto_ready_q), 16'h0);
        chk("pdown halt", 16'(halt_q), 16'h0);
        autorestart <= 1'b1;
        got_q = {};
        power_ok <= 1'b1;
        repeat (40) @(posedge clock);
        chk("auto first", got_q[0], START_LOC);
        chk("auto next", got_q[1], 16'h0007);
        power_ok <= 1'b0;
        repeat (3600) @(posedge clock);
        got_q = {};
        keys[2] <= 1'b1;
        power_ok <= 1'b1;
        repeat (40) @(posedge clock);
        chk("one instr", 16'(got_q.size()), 16'h1);
        chk("one instr sc", sc_q, 16'h0007);
        close_out();
    end
endmodule : cfo_console_bench

// ===== cfo_dec_if.sv
`timescale 1ns/1ps
interface cfo_dec_if;
    import cfo_pkg::*;
    logic [WORD_W-1:0] instr;
    logic [IND_W-1:0] status;
    logic is_fgen;
    logic is_ftest;
    logic two_word;
    logic test_pass;
    modport dec (input instr, input status, output is_fgen, output is_ftest, output two_word,
                 output test_pass);
    modport ctl (output instr, output status, input is_fgen, input is_ftest, input two_word,
                 input test_pass);
endinterface : cfo_dec_if

// ===== cfo_decode.sv
`timescale 1ns/1ps
module cfo_decode
    import cfo_pkg::*;
(
    // decode channel
    cfo_dec_if.dec d
);
    wire [ADDR_W-1:0] src = d.instr[SRC_LSB +: ADDR_W];
    wire [ADDR_W-1:0] dst = d.instr[DST_LSB +: ADDR_W];
    wire [MOD_W-1:0] modf = d.instr[MOD_LSB +: MOD_W];
    wire [IND_W-1:0] sel = modf[MOD_W-1:1];
    wire all_off = modf[0];
    wire any_on = |(sel & d.status);

    assign d.is_fgen = (src == DEV_FUNC);
    assign d.is_ftest = (dst == DEV_FUNC) && (src != DEV_FUNC);
    // memory reference and data test carry a second word
    assign d.two_word = (src == DEV_MEM) || (dst == DEV_MEM) || (dst == DEV_DTEST);
    assign d.test_pass = all_off ? ~any_on : any_on;
endmodule : cfo_decode

// ===== cfo_far_end.sv
`timescale 1ns/1ps
module cfo_far_end
    import cfo_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // memory
    input wire logic mem_rd_q,
    input wire logic [WORD_W-1:0] mem_addr_q,
    output logic [WORD_W-1:0] mem_rdata,
    output logic mem_ack,
    // devices
    input wire logic [ADDR_W-1:0] bus_src_q,
    input wire logic [MOD_W-1:0] func_pulse_q,
    output logic [WORD_W-1:0] bus_rdata,
    output logic [IND_W-1:0] bus_status,
    // teleprinter
    input wire logic tto_strobe_q,
    output logic tto_done
);
    logic [WORD_W-1:0] mem [64];
    logic [1:0] wait_q;
    logic slow_q;
    logic [3:0] done_q;
    logic [MOD_W-1:0] cmd_q;
    // indicators follow the address so the bench can predict them
    assign bus_status = bus_src_q[IND_W-1:0];
    assign bus_rdata = {10'h0, bus_src_q} ^ 16'h5a5a;
    assign tto_done = done_q[3];
    initial
    begin
        foreach (mem[i])
            mem[i] = 16'h2015;
    end
    // alternate prompt and slow answers; idle data toggles so no stale word looks valid
    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            mem_ack <= 1'b0;
            mem_rdata <= 16'h0;
            wait_q <= 2'h0;
            slow_q <= 1'b0;
            done_q <= 4'h0;
            cmd_q <= 4'h0;
        end
        else
        begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            done_q <= {done_q[2:0], tto_strobe_q};
            if (func_pulse_q != 4'h0)
                cmd_q <= func_pulse_q;
            if (mem_rd_q && !mem_ack && wait_q != 2'h0)
                wait_q <= wait_q - 2'h1;
            else if (mem_rd_q && !mem_ack)
            begin
                mem_ack <= 1'b1;
                mem_rdata <= mem[mem_addr_q[5:0]];
                slow_q <= !slow_q;
                wait_q <= slow_q ? 2'h0 : 2'h3;
            end
        end
    end
endmodule : cfo_far_end

// ===== cfo_pkg.sv
package cfo_pkg;
    // ------------------------------------------------------------
    // instruction word layout
    // ------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int ADDR_W = 6;
    localparam int MOD_W = 4;
    localparam int SRC_LSB = 10;
    localparam int MOD_LSB = 6;
    localparam int DST_LSB = 0;
    localparam int TTY_W = 8;
    localparam int IND_W = 3;

    // ------------------------------------------------------------
    // fixed device addresses (octal 02, 03, 06, 07, 10, 77)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] DEV_FUNC = 6'h02;
    localparam logic [ADDR_W-1:0] DEV_DTEST = 6'h03;
    localparam logic [ADDR_W-1:0] DEV_MEM = 6'h06;
    localparam logic [ADDR_W-1:0] DEV_SEQ = 6'h07;
    localparam logic [ADDR_W-1:0] DEV_SWITCH = 6'h08;
    localparam logic [ADDR_W-1:0] DEV_TTY = 6'h3f;

    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [WORD_W-1:0] START_LOC = 16'h0006;
    localparam logic [WORD_W-1:0] SKIP_STEP = 16'h0002;
    localparam logic [WORD_W-1:0] NEXT_STEP = 16'h0001;
    localparam int CLK_MHZ = 25;
    localparam int PDOWN_US = 140;
    localparam int PDOWN_CYC = PDOWN_US * CLK_MHZ;
    localparam int PDOWN_W = 12;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_OFF = 7'h01,
        ST_HALT = 7'h02,
        ST_FETCH = 7'h04,
        ST_DECODE = 7'h08,
        ST_FETCH2 = 7'h10,
        ST_EXEC = 7'h20,
        ST_PDOWN = 7'h40
    } cfo_state_e;
endpackage : cfo_pkg
